// ### scs_defs.svh
// Constants for the serial configuration slave
// Functional notes
// R1: Answer only address byte 11010010; ignore all others. Code also answers 11010011, direction bit ignored.
// R2: All configuration bits take defaults at reset, interface use optional.
// R3: Accept byte write, byte read, block write and block read.
// R4: Command bit 7 low means block access, high means byte access.
// R5: Byte access uses command bits 6:0 as byte index.
// R6: Host sets command bits 6:0 to zero for block access.
// R7: Block bytes move ascending from byte zero, MSB first.
// R8: Host may stop block after any complete byte; rest untouched.
// R9: Block write: address, command, count, data bytes, all acknowledged.
// R10: Block read: command, repeated start, read; count then data returned.
// R11: Host acknowledges block read bytes except the last.
// R12: Every block write data byte, including last, is acknowledged.
// R13: Written bits individually enable or disable clock output buffers.
// R14: Accesses accepted any time during operation.
// R15: Byte write: address, offset command, one data byte, stop.
// R16: Byte read: offset command, repeated start, one byte, host NAK.
// R17: Block read count is implemented byte total; extra writes ignored.
// R18: Stop or stray start releases data line, partial byte discarded.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_SLAVE_ADDR 8'hd2
`define SCS_CMD_BYTE_BIT 7
`define SCS_NUM_BYTES 8
`define SCS_BYTE_DEFAULTS 64'hffff_ffff_ffff_7f00
`endif

// ### scs_pkg.sv
// Types for the serial configuration slave
package scs_pkg;
	typedef enum logic [2:0] {
		SCS_IDLE,
		SCS_RX,
		SCS_RX_ACK,
		SCS_TX,
		SCS_TX_ACK
	} scs_phase_t;
	typedef enum logic [1:0] {
		SCS_F_ADDR,
		SCS_F_CMD,
		SCS_F_COUNT,
		SCS_F_DATA
	} scs_field_t;
endpackage

// ### scs_slave.sv
// Serial configuration slave with register bank
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_slave
	import scs_pkg::*;
#(
	parameter int NBYTES = `SCS_NUM_BYTES
)(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_o,
	output logic [NBYTES*8-1:0]        cfg_o
);
	typedef struct packed {
		logic [1:0]          scl_s;
		logic [1:0]          sda_s;
		logic                scl_d;
		logic                sda_d;
		scs_phase_t          phase;
		scs_field_t          field;
		logic [2:0]          bitn;
		logic [7:0]          shreg;
		logic                rd;
		logic                blk;
		logic [6:0]          idx;
		logic                first;
		logic                oe;
		logic [NBYTES*8-1:0] cfg;
	} scs_state_t;

	scs_state_t st;
	scs_state_t next_st;

	// Byte fetch from bank, zero when index beyond
	function automatic logic [7:0] rd_byte(input logic [NBYTES*8-1:0] b, input logic [6:0] i);
		logic [7:0] v;
		v = 8'h00;
		for (int k = 0; k < NBYTES; k++) begin
			if (i == 7'(k)) begin
				v = b[k*8 +: 8];
			end
		end
		return v;
	endfunction

	// Byte to shift out: count first in a block read
	function automatic logic [7:0] tx_byte(input logic blk, input logic first, input logic [NBYTES*8-1:0] b,
		input logic [6:0] i);
		logic [7:0] v;
		if (blk && first) begin
			v = 8'(NBYTES); // R17
		end else begin
			v = rd_byte(b, i); // R7
		end
		return v;
	endfunction

	// Address byte match, direction bit ignored
	function automatic logic addr_hit(input logic [7:0] a);
		logic [7:0] want;
		want = `SCS_SLAVE_ADDR;
		return a[7:1] == want[7:1]; // R1
	endfunction

	// Bank write: one byte lane selected by index
	function automatic logic [NBYTES*8-1:0] wr_byte(input logic [NBYTES*8-1:0] b, input logic [6:0] i,
		input logic [7:0] v);
		logic [NBYTES*8-1:0] n;
		n = b;
		for (int k = 0; k < NBYTES; k++) begin
			if (i == 7'(k)) begin
				n[k*8 +: 8] = v; // R13
			end
		end
		return n;
	endfunction

	// Index step, saturates so a long block stays harmless
	function automatic logic [6:0] idx_step(input logic [6:0] i);
		logic [6:0] n;
		n = i;
		if (i != 7'h7f) begin
			n = i + 7'd1;
		end
		return n;
	endfunction

	// Field that follows an acknowledged byte
	function automatic scs_field_t field_after(input scs_field_t f, input logic blk);
		scs_field_t n;
		case (f)
			SCS_F_ADDR: begin
				n = SCS_F_CMD;
			end
			SCS_F_CMD: begin
				n = blk ? SCS_F_COUNT : SCS_F_DATA; // R9 R15
			end
			default: begin
				n = SCS_F_DATA;
			end
		endcase
		return n;
	endfunction

	// Open-drain level: pull low only for a zero bit
	function automatic logic pull_low(input logic [7:0] s);
		return ~s[7];
	endfunction

	// Pin events seen through the synchronisers
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       ack_begin;
	logic       ack_end;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic [7:0] tx_next;
	assign scl_rise = st.scl_s[1] & ~st.scl_d;
	assign scl_fall = ~st.scl_s[1] & st.scl_d;
	// Start and stop: data edge while clock high
	assign start_c  = st.scl_s[1] & st.sda_d & ~st.sda_s[1];
	assign stop_c   = st.scl_s[1] & ~st.sda_d & st.sda_s[1];
	// Acknowledge slot edges and byte completion
	assign ack_begin = scl_fall & ~st.oe;
	assign ack_end   = scl_fall & st.oe;
	assign byte_done = scl_rise & (st.bitn == 3'd7);
	// Received byte including the bit now sampled
	assign rx_byte  = {st.shreg[6:0], st.sda_s[1]};
	// Next byte to send after an acknowledge
	assign tx_next  = tx_byte(st.blk, st.first, st.cfg, st.idx);

	// Next-state logic
	always_comb begin
		// Hold everything unless changed below
		next_st = st;
		// Synchroniser stages and delayed copies
		next_st.scl_s = {st.scl_s[0], scl_i};
		next_st.sda_s = {st.sda_s[0], sda_i};
		next_st.scl_d = st.scl_s[1];
		next_st.sda_d = st.sda_s[1];
		if (start_c) begin
			// Repeated start keeps command context for reads
			next_st.phase = SCS_RX; // R18
			next_st.field = SCS_F_ADDR;
			next_st.bitn  = 3'd0;
			next_st.oe    = 1'b0;
		end else if (stop_c) begin
			// Stop ends any transfer, even part way through a byte
			next_st.phase = SCS_IDLE; // R8 R18
			next_st.oe    = 1'b0;
		end else begin
			case (st.phase)
				SCS_IDLE: begin
					// Wait for a start, line released
					next_st.oe = 1'b0;
				end
				SCS_RX: begin
					// Shift in on clock rise, MSB first
					if (scl_rise) begin
						next_st.shreg = rx_byte; // R7
						next_st.bitn  = st.bitn + 3'd1;
						if (byte_done) begin
							// Last bit: acknowledge slot follows
							next_st.phase = SCS_RX_ACK;
						end
					end
				end
				SCS_RX_ACK: begin
					if (ack_begin) begin
						// Eighth bit done: decide on the acknowledge
						case (st.field)
							SCS_F_ADDR: begin
								if (addr_hit(st.shreg)) begin // R1
									// Ours: acknowledge, keep direction
									next_st.oe = 1'b1;
									next_st.rd = st.shreg[0];
								end else begin
									// Not ours: stay quiet until next start
									next_st.phase = SCS_IDLE;
								end
							end
							SCS_F_CMD: begin
								// Bit 7 picks byte or block access
								next_st.oe    = 1'b1;
								next_st.blk   = ~st.shreg[`SCS_CMD_BYTE_BIT]; // R4
								next_st.first = 1'b1;
								if (st.shreg[`SCS_CMD_BYTE_BIT]) begin
									next_st.idx = st.shreg[6:0]; // R5
								end else begin
									next_st.idx = 7'd0; // R6
								end
							end
							SCS_F_COUNT: begin
								// Count taken and acknowledged, value unused
								next_st.oe = 1'b1; // R9
							end
							default: begin
								// Data byte lands, index moves on
								next_st.oe  = 1'b1; // R12
								next_st.cfg = wr_byte(st.cfg, st.idx, st.shreg); // R13 R14 R15
								next_st.idx = idx_step(st.idx); // R17
							end
						endcase
					end else if (ack_end) begin
						// Acknowledge slot over: release and move on
						next_st.oe   = 1'b0;
						next_st.bitn = 3'd0;
						if (st.field == SCS_F_ADDR && st.rd) begin
							// Read: count first for block, else addressed byte
							next_st.phase = SCS_TX; // R10 R16
							next_st.shreg = tx_next;
							next_st.oe    = pull_low(tx_next);
						end else begin
							next_st.phase = SCS_RX;
							next_st.field = field_after(st.field, st.blk);
						end
					end
				end
				SCS_TX: begin
					// Shift out MSB first, output changes on falling edge
					next_st.oe = pull_low(st.shreg);
					if (scl_fall) begin
						next_st.bitn  = st.bitn + 3'd1;
						next_st.shreg = {st.shreg[6:0], 1'b1};
						if (st.bitn == 3'd7) begin
							// Byte sent: release for host acknowledge
							next_st.phase = SCS_TX_ACK;
							next_st.oe    = 1'b0;
						end else begin
							next_st.oe = pull_low({st.shreg[6:0], 1'b1});
						end
					end
				end
				SCS_TX_ACK: begin
					// Host drives its acknowledge now
					next_st.oe = 1'b0;
					if (scl_rise) begin
						if (st.sda_s[1]) begin
							// Host declined: transfer ends
							next_st.phase = SCS_IDLE; // R11
						end else if (st.blk && st.first) begin
							// Count byte taken, data starts at byte zero
							next_st.first = 1'b0;
						end else begin
							// Host acknowledged: step to next byte
							next_st.idx = idx_step(st.idx);
						end
					end else if (scl_fall) begin
						// Next byte loaded behind the acknowledge
						next_st.phase = SCS_TX;
						next_st.bitn  = 3'd0;
						next_st.shreg = tx_next;
						next_st.oe    = pull_low(tx_next);
					end
				end
				default: begin
					// Unused codes recover to idle
					next_st.phase = SCS_IDLE;
				end
			endcase
		end
	end

	// State register, bank returns to defaults on reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Lines seen idle high, machine idle
			st.scl_s <= 2'b11;
			st.sda_s <= 2'b11;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.phase <= SCS_IDLE;
			st.field <= SCS_F_ADDR;
			// Transfer context cleared
			st.bitn  <= 3'd0;
			st.shreg <= 8'h00;
			st.rd    <= 1'b0;
			st.blk   <= 1'b0;
			st.idx   <= 7'd0;
			st.first <= 1'b0;
			st.oe    <= 1'b0;
			// Bank at defaults
			st.cfg   <= (NBYTES*8)'(`SCS_BYTE_DEFAULTS); // R2
		end else begin
			st <= next_st; // R3
		end
	end

	// Open-drain data line: only ever pulls low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sda_o    <= 1'b0;
			sda_oe_o <= 1'b0;
			cfg_o    <= (NBYTES*8)'(`SCS_BYTE_DEFAULTS);
		end else begin
			sda_o    <= 1'b0;
			sda_oe_o <= next_st.oe;
			cfg_o    <= next_st.cfg;
		end
	end
endmodule

// ### scs_slave_properties.sv
// Pin checks for the configuration slave
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_slave_properties
	import scs_pkg::*;
#(
	parameter int NBYTES = 8
)(
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                scl_i,
	input wire logic                sda_i,
	input wire logic                sda_o,
	input wire logic                sda_oe_o,
	input wire logic [NBYTES*8-1:0] cfg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Start and stop while the clock is high
	sequence start_s; scl_i && $past(scl_i) && $fell(sda_i); endsequence
	sequence stop_s; scl_i && $past(scl_i) && $rose(sda_i); endsequence
	// Data pin and bank relations
	chk_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
	chk_reset_bank: assert property ($fell(rst_i) |-> cfg_o == `SCS_BYTE_DEFAULTS) else $error("bad bank");
	chk_reset_free: assert property ($fell(rst_i) |-> !sda_oe_o) else $error("sda held at reset");
	chk_start_free: assert property (start_s |-> !sda_oe_o) else $error("sda held at start");
	chk_stop_release: assert property (stop_s |=> !sda_oe_o [*8]) else $error("sda held after stop");
	chk_high_stable: assert property (scl_i && $past(scl_i, 2) |-> $stable(sda_oe_o)) else $error("sda moved");
	chk_ack_width: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8]) else $error("drive too short");
	chk_drive_bound: assert property ($rose(sda_oe_o) |-> ##[1:200] !sda_oe_o) else $error("drive too long");
endmodule
bind scs_slave scs_slave_properties #(.NBYTES(NBYTES)) scs_slave_properties_i (.clk_i(clk_i), .rst_i(rst_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cfg_o(cfg_o));

// ### scs_host.sv
// Bus host model for the two-wire link
`timescale 1ns/10ps
module scs_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// Both lines idle high
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// One quarter bit: set lines, wait four clocks
	task ph(input logic c, input logic s);
		scl_o = c;
		sda_o = s;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// Start or repeated start
	task start();
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
	endtask
	// Stop after a whole byte
	task stop();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b1);
	endtask
	// Nine slots MSB first, last is acknowledge
	task xfer(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			ph(1'b0, w[i]);
			ph(1'b1, w[i]);
			r[i] = sda_i;
			ph(1'b1, w[i]);
			ph(1'b0, w[i]);
		end
	endtask
endmodule

// ### scs_slave_tb.sv
// Self-checking bench for the configuration slave
`timescale 1ns/10ps
`include "scs_defs.svh"
module scs_slave_tb;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        scl_i;
	logic        sda_i;
	logic        hsda;
	logic        sda_oe_o;
	logic [63:0] cfg_o;
	logic [63:0] bank;
	logic [8:0]  r;
	logic [7:0]  d;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          seed = 15;
	int          nb[3] = '{3, 8, 10};
	// Clock and pulled-up data wire
	always #5 clk_i = ~clk_i;
	assign sda_i = hsda & ~sda_oe_o;
	scs_slave scs_slave_i (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(),
		.sda_oe_o(sda_oe_o), .cfg_o(cfg_o));
	scs_host scs_host_i (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(hsda));
	// Expected bank after a byte lands
	function automatic logic [63:0] put(input logic [63:0] b, input int k, input logic [7:0] v);
		if (k < 8)
			b[8*k+:8] = v;
		return b;
	endfunction
	task check(input logic [63:0] seen, input logic [63:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task wb(input logic [7:0] v);
		scs_host_i.xfer({v, 1'b1}, r);
		check(r[0], 1'b0);
	endtask
	task rb(input logic [7:0] want, input logic last);
		scs_host_i.xfer({8'hff, last}, r);
		check(r[8:1], want);
	endtask
	task open(input logic [7:0] cmd, input logic rd);
		scs_host_i.start();
		wb(8'hd2);
		wb(cmd);
		if (rd) begin
			scs_host_i.start();
			wb(8'hd3);
		end
	endtask
	task final_report();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		#1 rst_i = 0;
		bank = `SCS_BYTE_DEFAULTS;
		repeat (3) @(posedge clk_i);
		check(cfg_o, bank);
		scs_host_i.start();
		scs_host_i.xfer({8'hd0, 1'b1}, r);
		check(r[0], 1'b1);
		scs_host_i.stop();
		for (int k = 7; k >= 0; k--) begin
			d = $random(seed);
			open({1'b1, 7'(k)}, 1'b0);
			wb(d);
			scs_host_i.stop();
			bank = put(bank, k, d);
			check(cfg_o, bank);
			open({1'b1, 7'(k)}, 1'b1);
			rb(bank[8*k+:8], 1'b1);
			scs_host_i.stop();
		end
		foreach (nb[i]) begin
			open(8'h00, 1'b0);
			wb(8'(nb[i]));
			for (int k = 0; k < nb[i]; k++) begin
				d = $random(seed);
				wb(d);
				bank = put(bank, k, d);
			end
			scs_host_i.stop();
			check(cfg_o, bank);
			open(8'h00, 1'b1);
			rb(8'd8, 1'b0);
			for (int k = 0; k < 8; k++)
				rb(bank[8*k+:8], k == 7);
			scs_host_i.stop();
		end
		final_report();
	end
endmodule
